// ==== stmf_pkg.sv ====
// Package: constants, types and helpers of the S/T multiframe block
// =====================================================================
// What this block does
// - TE in sync sends Q in every fifth FA
// - TE out of sync mirrors received FA
// - Sync gained after two good multiframes
// - Sync lost after two bad multiframes
// - Sync state readable in receive register one
// - Enable bit in transmit register gates sync
// - NT builds multiframes only when enabled
// - NT sends S data in S positions
// - Window event once per multiframe
// - Change event when received S/Q differs
// - Select bit turns aux pin into sync pin
// - Sync pin sampled at frame start
// - High input holds frame 20, zero bits
// - Low input restarts count at frame 1
// - Frame 1 sends FA, M one and S11
// - TE/trunk drive received M onto pin
// - TE passes B/D/E when active or smdis transparent, else ones
// - NT passes B/D when active or smdis transparent, else ones
// - TE line data needs request or enable
package stmf_pkg;
   // =====================================================================
   // Register map
   localparam logic [7:0] OFS_SQ_TRANSMIT_ONE = 8'h00;
   localparam logic [7:0] OFS_SQ_RECEIVE_ONE = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam int SQ_DATA_W = 4;
   localparam int SQX_MFRAME_ENABLE_BIT = 4;
   localparam int SQR_MFRAME_SYNC_FLAG_BIT = 4;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_AUX_FOUR_SELECT_BIT = 2;
   localparam int CFG_SMDIS_BIT = 3;
   localparam int CFG_TRANSMIT_INFO_SELECT_LSB = 4;
   localparam int CFG_TRANSMIT_DATA_DISABLE_BIT = 7;
   localparam int CFG_WIN_EN_BIT = 8;
   localparam int CFG_CHG_EN_BIT = 9;
   localparam logic [31:0] SQX_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_RESET = 32'h0000_0080;
   // =====================================================================
   // Multiframe figures
   localparam logic [4:0] MF_FIRST = 5'h01;
   localparam logic [4:0] MF_LEN = 5'h14;
   localparam logic [1:0] SYNC_GAIN = 2'h2;
   localparam logic [1:0] SYNC_LOSS = 2'h2;
   localparam logic [2:0] TRANSMIT_INFO_SELECT_TRANSP = 3'h3;
   localparam logic [7:0] B_ONES = 8'hFF;
   // =====================================================================
   // Types
   typedef enum logic [1:0] {
      MODE_TE = 2'b00, MODE_NT = 2'b01, MODE_LTS = 2'b10, MODE_LTT = 2'b11
   } stmf_mode_t;
   typedef enum logic [1:0] {
      ST_HUNT = 2'b00, ST_CHECK = 2'b01, ST_SYNC = 2'b10
   } stmf_sync_t;
   typedef struct packed {
      logic fa;
      logic n;
      logic m;
      logic s;
   } stmf_rxfrm_t;
   typedef struct packed {
      logic fa;
      logic m;
      logic s;
   } stmf_txfrm_t;
   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] d;
      logic e;
   } stmf_bits_t;
   typedef struct packed {
      stmf_mode_t mode;
      logic aux_four_select;
      logic smdis;
      logic [2:0] transmit_info_select;
      logic transmit_data_disable;
      logic win_en;
      logic chg_en;
   } stmf_cfg_t;
   // =====================================================================
   // Frames 1, 6, 11 and 16 carry the S1 and Q slots
   function automatic logic stmf_slot_hit(input logic [4:0] cnt);
      return (cnt == 5'h01) || (cnt == 5'h06) || (cnt == 5'h0B) || (cnt == 5'h10);
   endfunction : stmf_slot_hit
   function automatic logic [1:0] stmf_slot_idx(input logic [4:0] cnt);
      logic [1:0] idx;
      idx = 2'h0;
      if (cnt > 5'h0A) begin
         idx = (cnt > 5'h0F) ? 2'h3 : 2'h2;
      end else if (cnt > 5'h05) begin
         idx = 2'h1;
      end
      return idx;
   endfunction : stmf_slot_idx
   // Counter advance with wrap from frame 20 to frame 1
   function automatic logic [4:0] stmf_adv(input logic [4:0] cnt);
      return (cnt >= MF_LEN) ? MF_FIRST : cnt + 5'h01;
   endfunction : stmf_adv
endpackage : stmf_pkg

// ==== stmf_core.sv ====
// Module: S/T multiframe sync, S/Q insertion, sync pin and data gating
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module stmf_core
   import stmf_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Frame timing and framing bits
   input wire logic FRAME_START,
   input wire logic RX_DONE,
   input wire stmf_rxfrm_t RX_FRAME,
   output stmf_txfrm_t TX_FRAME,
   // Layer-1 state
   input wire logic ACTIVATED_STATE,
   input wire logic ACTIVATION_REQUEST_PRIO8,
   input wire logic ACTIVATION_REQUEST_PRIO10,
   input wire logic ACTIVATION_REQUEST_LOOP,
   // Line to highway data
   input wire logic LINE_RX_VALID,
   input wire stmf_bits_t LINE_RX,
   output logic HWY_TX_VALID,
   output stmf_bits_t HWY_TX,
   // Highway to line data
   input wire logic HWY_RX_VALID,
   input wire stmf_bits_t HWY_RX,
   output logic LINE_TX_VALID,
   output stmf_bits_t LINE_TX,
   // Aux pin four
   input wire logic AUX_PIN_FOUR_IN,
   output logic AUX_PIN_FOUR_OUT,
   output logic AUX_PIN_FOUR_OE,
   input wire logic GPIO_OUT,
   input wire logic GPIO_OE,
   // Events
   output logic MFRAME_WINDOW_IRQ,
   output logic SQ_CHANGE_IRQ
);
   // =====================================================================
   // State
   typedef struct packed {
      logic mframe_enable;
      logic [SQ_DATA_W-1:0] sq_tx;
      stmf_cfg_t cfg;
      logic [31:0] rdata;
      stmf_sync_t sync;
      logic [4:0] cnt;
      logic [1:0] good;
      logic [1:0] bad;
      logic err;
      logic [4:0] ntcnt;
      logic nt_hold;
      logic [SQ_DATA_W-1:0] acc;
      logic [SQ_DATA_W-1:0] sq_rx;
      stmf_txfrm_t txf;
      logic mframe_sync_pin;
      logic aux_out;
      logic aux_oe;
      stmf_bits_t hwy;
      logic hwy_valid;
      stmf_bits_t line;
      logic line_valid;
      logic win_irq;
      logic chg_irq;
   } stmf_state_t;

   stmf_state_t s;
   stmf_state_t next_s;
   logic te_side;
   logic nt_side;
   logic [4:0] cur;
   logic mismatch;
   logic pass_rx;
   logic pass_tx;
   logic act_req;
   logic mframe_sync_pin_hold;
   logic [4:0] nt_next;

   // Mode grouping and per-frame terms
   always_comb begin
      te_side = (s.cfg.mode == MODE_TE) || (s.cfg.mode == MODE_LTT);
      nt_side = !te_side;
      cur = (s.sync == ST_HUNT) ? MF_FIRST : stmf_adv(s.cnt);
      mismatch = (RX_FRAME.fa != stmf_slot_hit(cur)) || (RX_FRAME.m != (cur == MF_FIRST))
         || (RX_FRAME.n == RX_FRAME.fa);
      act_req = ACTIVATION_REQUEST_PRIO8 || ACTIVATION_REQUEST_PRIO10 || ACTIVATION_REQUEST_LOOP;
      pass_rx = ACTIVATED_STATE || (s.cfg.smdis && (s.cfg.transmit_info_select == TRANSMIT_INFO_SELECT_TRANSP));
      pass_tx = pass_rx;
      if (te_side) begin
         pass_tx = (ACTIVATED_STATE && act_req) || (s.cfg.smdis
            && (s.cfg.transmit_info_select == TRANSMIT_INFO_SELECT_TRANSP) && !s.cfg.transmit_data_disable);
      end
      mframe_sync_pin_hold = s.cfg.aux_four_select && AUX_PIN_FOUR_IN;
      nt_next = (mframe_sync_pin_hold || !s.mframe_enable) ? MF_LEN : stmf_adv(s.ntcnt);
   end

   // Next state
   always_comb begin
      next_s = s;
      next_s.win_irq = 1'b0;
      next_s.chg_irq = 1'b0;
      next_s.hwy_valid = 1'b0;
      next_s.line_valid = 1'b0;
      next_s.rdata = 32'h0000_0000;
      // Register writes
      if (REG_WR) begin
         case (REG_ADDR)
            OFS_SQ_TRANSMIT_ONE: begin
               next_s.mframe_enable = REG_WDATA[SQX_MFRAME_ENABLE_BIT];
               next_s.sq_tx = REG_WDATA[SQ_DATA_W-1:0];
            end
            OFS_CONFIG: begin
               next_s.cfg.mode = stmf_mode_t'(REG_WDATA[CFG_MODE_LSB +: 2]);
               next_s.cfg.aux_four_select = REG_WDATA[CFG_AUX_FOUR_SELECT_BIT];
               next_s.cfg.smdis = REG_WDATA[CFG_SMDIS_BIT];
               next_s.cfg.transmit_info_select = REG_WDATA[CFG_TRANSMIT_INFO_SELECT_LSB +: 3];
               next_s.cfg.transmit_data_disable = REG_WDATA[CFG_TRANSMIT_DATA_DISABLE_BIT];
               next_s.cfg.win_en = REG_WDATA[CFG_WIN_EN_BIT];
               next_s.cfg.chg_en = REG_WDATA[CFG_CHG_EN_BIT];
            end
            default: begin
            end
         endcase
      end
      // Register reads, unmapped reads return zero
      if (REG_RD) begin
         case (REG_ADDR)
            OFS_SQ_TRANSMIT_ONE: begin
               next_s.rdata[SQX_MFRAME_ENABLE_BIT] = s.mframe_enable;
               next_s.rdata[SQ_DATA_W-1:0] = s.sq_tx;
            end
            OFS_SQ_RECEIVE_ONE: begin
               next_s.rdata[SQR_MFRAME_SYNC_FLAG_BIT] = te_side && (s.sync == ST_SYNC);
               next_s.rdata[SQ_DATA_W-1:0] = s.sq_rx;
            end
            OFS_CONFIG: begin
               next_s.rdata[CFG_MODE_LSB +: 2] = s.cfg.mode;
               next_s.rdata[CFG_AUX_FOUR_SELECT_BIT] = s.cfg.aux_four_select;
               next_s.rdata[CFG_SMDIS_BIT] = s.cfg.smdis;
               next_s.rdata[CFG_TRANSMIT_INFO_SELECT_LSB +: 3] = s.cfg.transmit_info_select;
               next_s.rdata[CFG_TRANSMIT_DATA_DISABLE_BIT] = s.cfg.transmit_data_disable;
               next_s.rdata[CFG_WIN_EN_BIT] = s.cfg.win_en;
               next_s.rdata[CFG_CHG_EN_BIT] = s.cfg.chg_en;
            end
            default: begin
            end
         endcase
      end
      // TE side: multiframe hunt and check on each received frame
      if (!s.mframe_enable || nt_side) begin
         next_s.sync = ST_HUNT;
         next_s.good = 2'h0;
         next_s.bad = 2'h0;
         next_s.err = 1'b0;
      end else if (RX_DONE) begin
         case (s.sync)
            ST_HUNT: begin
               if (RX_FRAME.m && !mismatch) begin
                  next_s.sync = ST_CHECK;
                  next_s.cnt = MF_FIRST;
                  next_s.good = 2'h0;
               end
            end
            ST_CHECK: begin
               next_s.cnt = cur;
               if (mismatch) begin
                  next_s.sync = ST_HUNT;
               end else if (cur == MF_LEN) begin
                  next_s.good = s.good + 2'h1;
                  if (s.good + 2'h1 == SYNC_GAIN) begin
                     next_s.sync = ST_SYNC;
                     next_s.bad = 2'h0;
                     next_s.err = 1'b0;
                  end
               end
            end
            ST_SYNC: begin
               next_s.cnt = cur;
               next_s.err = s.err || mismatch;
               if (cur == MF_LEN) begin
                  next_s.err = 1'b0;
                  next_s.bad = 2'h0;
                  if (s.err || mismatch) begin
                     next_s.bad = s.bad + 2'h1;
                     if (s.bad + 2'h1 == SYNC_LOSS) begin
                        next_s.sync = ST_HUNT;
                     end
                  end
               end
            end
            default: begin
               next_s.sync = ST_HUNT;
            end
         endcase
      end
      // TE side: upstream FA, S1 collection and M onto the pin
      if (te_side && RX_DONE) begin
         next_s.mframe_sync_pin = RX_FRAME.m;
         next_s.txf = '0;
         if (s.sync == ST_SYNC) begin
            next_s.txf.fa = stmf_slot_hit(cur) && s.sq_tx[stmf_slot_idx(cur)];
         end else begin
            next_s.txf.fa = RX_FRAME.fa;
         end
         if (stmf_slot_hit(cur)) begin
            next_s.acc[stmf_slot_idx(cur)] = RX_FRAME.s;
         end
         if ((s.sync == ST_SYNC) && (cur == MF_LEN)) begin
            next_s.sq_rx = s.acc;
            next_s.win_irq = s.cfg.win_en;
            next_s.chg_irq = s.cfg.chg_en && (s.acc != s.sq_rx);
         end
      end
      // NT side: multiframe generation at each frame start
      if (nt_side && FRAME_START) begin
         next_s.ntcnt = nt_next;
         next_s.nt_hold = mframe_sync_pin_hold;
         next_s.txf = '0;
         if (s.mframe_enable && !mframe_sync_pin_hold) begin
            next_s.txf.fa = stmf_slot_hit(nt_next);
            next_s.txf.m = (nt_next == MF_FIRST);
            next_s.txf.s = stmf_slot_hit(nt_next) && s.sq_tx[stmf_slot_idx(nt_next)];
         end
      end
      // NT side: Q collection from received FA
      if (nt_side && RX_DONE && s.mframe_enable && !s.nt_hold) begin
         if (stmf_slot_hit(s.ntcnt)) begin
            next_s.acc[stmf_slot_idx(s.ntcnt)] = RX_FRAME.fa;
         end
         if (s.ntcnt == MF_LEN) begin
            next_s.sq_rx = s.acc;
            next_s.win_irq = s.cfg.win_en;
            next_s.chg_irq = s.cfg.chg_en && (s.acc != s.sq_rx);
         end
      end
      // Aux pin four: sync pin or general output
      if (s.cfg.aux_four_select) begin
         next_s.aux_oe = te_side;
         next_s.aux_out = te_side && s.mframe_sync_pin;
      end else begin
         next_s.aux_oe = GPIO_OE;
         next_s.aux_out = GPIO_OUT;
      end
      // Line to highway, E only in TE modes
      if (LINE_RX_VALID) begin
         next_s.hwy_valid = 1'b1;
         next_s.hwy = '1;
         if (pass_rx) begin
            next_s.hwy = LINE_RX;
            next_s.hwy.e = te_side ? LINE_RX.e : 1'b1;
         end
      end
      // Highway to line
      if (HWY_RX_VALID) begin
         next_s.line_valid = 1'b1;
         next_s.line = pass_tx ? HWY_RX : '1;
      end
   end

   // State register
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         s <= '0;
         s.mframe_enable <= SQX_RESET[SQX_MFRAME_ENABLE_BIT];
         s.cfg.transmit_data_disable <= CFG_RESET[CFG_TRANSMIT_DATA_DISABLE_BIT];
         s.cnt <= MF_LEN;
         s.ntcnt <= MF_LEN;
         s.sync <= ST_HUNT;
         s.hwy <= '1;
         s.line <= '1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs
   assign REG_RDATA = s.rdata;
   assign TX_FRAME = s.txf;
   assign HWY_TX_VALID = s.hwy_valid;
   assign HWY_TX = s.hwy;
   assign LINE_TX_VALID = s.line_valid;
   assign LINE_TX = s.line;
   assign AUX_PIN_FOUR_OUT = s.aux_out;
   assign AUX_PIN_FOUR_OE = s.aux_oe;
   assign MFRAME_WINDOW_IRQ = s.win_irq;
   assign SQ_CHANGE_IRQ = s.chg_irq;

   // =====================================================================
   // Assertions
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   property p_q_slot_only;
      (te_side && RX_DONE && s.sync == ST_SYNC && !stmf_slot_hit(cur)) |=> !TX_FRAME.fa;
   endproperty
   a_q_slot_only: assert property (p_q_slot_only) else $error("FA set outside a Q slot");
   property p_fa_mirror;
      (te_side && RX_DONE && s.sync != ST_SYNC) |=> (TX_FRAME.fa == $past(RX_FRAME.fa));
   endproperty
   a_fa_mirror: assert property (p_fa_mirror) else $error("FA not mirrored");
   property p_gain;
      (s.sync == ST_SYNC && $past(s.sync) == ST_CHECK) |-> ($past(s.good) == 2'h1
         && $past(cur) == MF_LEN);
   endproperty
   a_gain: assert property (p_gain) else $error("Sync gained early");
   property p_loss;
      (te_side && s.mframe_enable && $past(te_side && s.mframe_enable)
         && $past(s.sync) == ST_SYNC && s.sync == ST_HUNT) |-> ($past(s.bad) == 2'h1);
   endproperty
   a_loss: assert property (p_loss) else $error("Sync lost after one bad multiframe");
   property p_mframe_sync_flag_read;
      (REG_RD && REG_ADDR == OFS_SQ_RECEIVE_ONE) |=>
         (REG_RDATA[SQR_MFRAME_SYNC_FLAG_BIT] == $past(te_side && s.sync == ST_SYNC));
   endproperty
   a_mframe_sync_flag_read: assert property (p_mframe_sync_flag_read) else $error("Sync flag misreported");
   property p_disable;
      !s.mframe_enable |=> (s.sync == ST_HUNT);
   endproperty
   a_disable: assert property (p_disable) else $error("Sync kept while disabled");
   property p_nt_off;
      (nt_side && FRAME_START && !s.mframe_enable) |=> (TX_FRAME == '0);
   endproperty
   a_nt_off: assert property (p_nt_off) else $error("Multiframe bits while disabled");
   property p_hold;
      (nt_side && FRAME_START && mframe_sync_pin_hold) |=> (s.ntcnt == MF_LEN && TX_FRAME == '0);
   endproperty
   a_hold: assert property (p_hold) else $error("Sync input did not hold frame 20");
   property p_first;
      (nt_side && FRAME_START && s.mframe_enable && !mframe_sync_pin_hold && s.ntcnt == MF_LEN) |=>
         (TX_FRAME.fa && TX_FRAME.m && s.ntcnt == MF_FIRST);
   endproperty
   a_first: assert property (p_first) else $error("Frame 1 bits missing");
   property p_ones;
      (LINE_RX_VALID && !pass_rx) |=> (HWY_TX_VALID && HWY_TX == '1);
   endproperty
   a_ones: assert property (p_ones) else $error("Highway not all ones");
   property p_pin_dir;
      s.cfg.aux_four_select |=> (AUX_PIN_FOUR_OE == $past(te_side));
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("Sync pin direction wrong");
   property p_s_first;
      (nt_side && FRAME_START && s.mframe_enable && !mframe_sync_pin_hold && nt_next == MF_FIRST) |=>
         (TX_FRAME.s == $past(s.sq_tx[0]));
   endproperty
   a_s_first: assert property (p_s_first) else $error("S11 bit not sent");
   property p_win_gap;
      MFRAME_WINDOW_IRQ |=> (!MFRAME_WINDOW_IRQ) [*8];
   endproperty
   a_win_gap: assert property (p_win_gap) else $error("Window event repeated");
   property p_chg_diff;
      SQ_CHANGE_IRQ |-> (s.sq_rx != $past(s.sq_rx));
   endproperty
   a_chg_diff: assert property (p_chg_diff) else $error("Change event, data same");
   property p_pin_m;
      (te_side && s.cfg.aux_four_select) |=> (AUX_PIN_FOUR_OUT == $past(s.mframe_sync_pin));
   endproperty
   a_pin_m: assert property (p_pin_m) else $error("Sync pin does not follow M");
   property p_e_forced;
      (nt_side && LINE_RX_VALID) |=> HWY_TX.e;
   endproperty
   a_e_forced: assert property (p_e_forced) else $error("E bit not forced");
   property p_line_block;
      (te_side && HWY_RX_VALID && !ACTIVATED_STATE && !s.cfg.smdis) |=> (LINE_TX == '1);
   endproperty
   a_line_block: assert property (p_line_block) else $error("Line data not blocked");

   c_sync: cover property (s.sync == ST_CHECK ##[1:1000] s.sync == ST_SYNC);
   c_win: cover property (MFRAME_WINDOW_IRQ);
   c_chg: cover property (SQ_CHANGE_IRQ);
   c_restart: cover property (nt_side && s.nt_hold ##1 !s.nt_hold && s.ntcnt == MF_FIRST);
endmodule : stmf_core
`default_nettype wire

// ==== stmf_far_end.sv ====
// Far-end network termination model: frame strobes and received framing bits
`timescale 1ns/1ps
`default_nettype none
module stmf_far_end
   import stmf_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Bench control
   input wire logic [3:0] S_PAT,
   input wire logic ERR,
   // Frame link
   output logic FRAME_START,
   output logic RX_DONE,
   output stmf_rxfrm_t RX_FRAME,
   output logic [4:0] FRM
);
   logic [4:0] ph;
   logic [4:0] idx;
   logic slot;
   // Frames 1, 6, 11 and 16 carry FA one and an S1 bit
   assign slot = (FRM == 5'h01) || (FRM == 5'h06) || (FRM == 5'h0B) || (FRM == 5'h10);
   assign idx = (FRM - 5'h01) / 5'h05;
   // =====================================================================
   // One frame every 20 cycles, framing bits handed over mid-frame
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ph <= 5'h00;
         FRM <= 5'h01;
         RX_FRAME <= '0;
         RX_DONE <= 1'b0;
         FRAME_START <= 1'b0;
      end else begin
         ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
         FRAME_START <= (ph == 5'h00);
         RX_DONE <= (ph == 5'h0A);
         if (ph == 5'h0A) begin
            RX_FRAME.fa <= slot ^ (ERR && (FRM == 5'h06));
            RX_FRAME.n <= !slot;
            RX_FRAME.m <= (FRM == 5'h01);
            RX_FRAME.s <= slot && S_PAT[idx[1:0]];
         end else if (ph == 5'h0B) begin
            // Released bits never keep the last value
            RX_FRAME <= ~RX_FRAME;
            FRM <= (FRM == 5'h14) ? 5'h01 : FRM + 5'h01;
         end
      end
   end
endmodule : stmf_far_end
`default_nettype wire

// ==== stmf_core_tb.sv ====
// Testbench of the S/T multiframe block
`timescale 1ns/1ps
`default_nettype none
module stmf_core_tb
   import stmf_pkg::*;
;
   localparam logic [18:0] LP = {8'h5A, 8'hC3, 2'h1, 1'h0};
   localparam logic [18:0] HP = {8'h3C, 8'h96, 2'h2, 1'h1};
   logic SYS_CLK, SYS_RST, REG_WR, REG_RD, FRAME_START, RX_DONE, err;
   logic [7:0] REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, rd;
   stmf_rxfrm_t RX_FRAME;
   stmf_txfrm_t TX_FRAME;
   logic act, ar8, activation_request_prio10, activation_request_loop, lrx_v, htx_v, hrx_v, ltx_v;
   logic pin_in, pin_out, pin_oe, gp_out, gp_oe, win_irq, chg_irq;
   stmf_bits_t lrx, htx, hrx, ltx;
   logic [3:0] s_pat;
   logic [4:0] frm;
   logic [4:0] kk [5];
   logic efa [5];
   logic [2:0] ntx [5];
   logic [15:0] gt [12];
   int err_count, num_checks, win_cnt, chg_cnt, i;
   stmf_core u_stmf_core (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .FRAME_START(FRAME_START), .RX_DONE(RX_DONE), .RX_FRAME(RX_FRAME), .TX_FRAME(TX_FRAME),
      .ACTIVATED_STATE(act), .ACTIVATION_REQUEST_PRIO8(ar8), .ACTIVATION_REQUEST_PRIO10(activation_request_prio10),
      .ACTIVATION_REQUEST_LOOP(activation_request_loop), .LINE_RX_VALID(lrx_v), .LINE_RX(lrx), .HWY_TX_VALID(htx_v),
      .HWY_TX(htx), .HWY_RX_VALID(hrx_v), .HWY_RX(hrx), .LINE_TX_VALID(ltx_v), .LINE_TX(ltx),
      .AUX_PIN_FOUR_IN(pin_in), .AUX_PIN_FOUR_OUT(pin_out), .AUX_PIN_FOUR_OE(pin_oe),
      .GPIO_OUT(gp_out), .GPIO_OE(gp_oe), .MFRAME_WINDOW_IRQ(win_irq), .SQ_CHANGE_IRQ(chg_irq));
   stmf_far_end u_stmf_far_end (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .S_PAT(s_pat), .ERR(err),
      .FRAME_START(FRAME_START), .RX_DONE(RX_DONE), .RX_FRAME(RX_FRAME), .FRM(frm));
   // =====================================================================
   // Clock and event counters
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      if (win_irq === 1'b1) win_cnt++;
      if (chg_irq === 1'b1) chg_cnt++;
   end
   // =====================================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic test_done;
      $display("Checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rdv(input logic [7:0] a);
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 rd = REG_RDATA;
   endtask : rdv
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      rdv(a);
      chk(nm, exp, rd);
   endtask : rdc
   // Bounded waits for a received frame number or a frame start
   task automatic wait_rx(input logic [4:0] k);
      for (int n = 0; n < 2000; n++) begin
         @(posedge SYS_CLK);
         if (RX_DONE === 1'b1 && frm === k) begin
            #1;
            return;
         end
      end
      err_count++;
      $display("ERROR wait for frame %0d timed out", k);
      test_done();
   endtask : wait_rx
   task automatic wait_fs(input int cnt);
      for (int n = 0; n < 400; n++) begin
         @(posedge SYS_CLK);
         if (FRAME_START === 1'b1) cnt--;
         if (cnt == 0) begin
            #1;
            return;
         end
      end
      err_count++;
      $display("ERROR wait for frame start timed out");
      test_done();
   endtask : wait_fs
   // One data word each way under a gating case
   task automatic gate(input logic [15:0] g);
      logic [18:0] erx;
      erx = g[12] ? ((g[1] ^ g[0]) ? {LP[18:1], 1'b1} : LP) : 19'h7_FFFF;
      wr(8'h08, {24'h00_0000, g[7:0]});
      @(posedge SYS_CLK);
      {activation_request_loop, activation_request_prio10, ar8, act} <= g[11:8];
      {lrx_v, hrx_v} <= 2'b11;
      lrx <= LP;
      hrx <= HP;
      @(posedge SYS_CLK);
      {lrx_v, hrx_v} <= 2'b00;
      lrx <= ~LP;
      hrx <= ~HP;
      #1 chk("hwy valid", 1, htx_v);
      chk("hwy data", erx, htx);
      chk("line valid", 1, ltx_v);
      chk("line data", g[13] ? HP : 19'h7_FFFF, ltx);
   endtask : gate
   // =====================================================================
   // Main sequence
   initial begin
      {SYS_RST, REG_WR, REG_RD, err, act, ar8, activation_request_prio10, activation_request_loop} = 8'h80;
      {lrx_v, hrx_v, pin_in, gp_out, gp_oe} = 5'h00;
      REG_ADDR = 8'h00;
      REG_WDATA = 32'h0000_0000;
      lrx = '1;
      hrx = '1;
      s_pat = 4'h9;
      {err_count, num_checks, win_cnt, chg_cnt} = '0;
      kk = '{5'h01, 5'h02, 5'h06, 5'h0B, 5'h10};
      efa = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      ntx = '{3'h7, 3'h4, 3'h4, 3'h5, 3'h7};
      gt = '{16'h0080, 16'h1180, 16'h3380, 16'h3580, 16'h3980, 16'h10B8,
         16'h3038, 16'h0028, 16'h0280, 16'h3181, 16'h0281, 16'h3182};
      repeat (5) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      rdc("sqx reset", 8'h00, SQX_RESET);
      rdc("sqr reset", 8'h04, 32'h0000_0000);
      rdc("cfg reset", 8'h08, CFG_RESET);
      rdc("unmapped", 8'h0C, 32'h0000_0000);
      $display("Test reset done");
      // Terminal side, multiframing off: FA is mirrored and no sync
      wr(8'h08, 32'h0000_0384);
      wait_rx(5'h01);
      chk("fa mirror", 1, TX_FRAME.fa);
      wait_rx(5'h02);
      chk("fa mirror", 0, TX_FRAME.fa);
      repeat (3) wait_rx(5'h14);
      rdv(8'h04);
      chk("sync off", 0, rd[SQR_MFRAME_SYNC_FLAG_BIT]);
      // Enable, gain sync, then Q slots, sync pin and window event
      wr(8'h00, 32'h0000_0016);
      repeat (4) wait_rx(5'h14);
      rdc("sync on", 8'h04, 32'h0000_0019);
      repeat (4) @(posedge SYS_CLK);
      {win_cnt, chg_cnt} = '0;
      for (i = 0; i < 5; i++) begin
         wait_rx(kk[i]);
         chk("q fa", efa[i], TX_FRAME.fa);
         @(posedge SYS_CLK);
         #1 chk("pin out", kk[i] == 5'h01, pin_out);
         chk("pin oe", 1, pin_oe);
      end
      wait_rx(5'h14);
      repeat (4) @(posedge SYS_CLK);
      chk("window count", 1, win_cnt);
      chk("change count", 0, chg_cnt);
      @(posedge SYS_CLK);
      s_pat <= 4'h6;
      repeat (2) wait_rx(5'h14);
      repeat (4) @(posedge SYS_CLK);
      chk("change count", 1, chg_cnt);
      rdc("s1 data", 8'h04, 32'h0000_0016);
      $display("Test sync gain done");
      // One bad multiframe keeps sync, two in a row lose it
      wait_rx(5'h01);
      @(posedge SYS_CLK) err <= 1'b1;
      wait_rx(5'h14);
      @(posedge SYS_CLK) err <= 1'b0;
      rdv(8'h04);
      chk("sync kept", 1, rd[SQR_MFRAME_SYNC_FLAG_BIT]);
      wait_rx(5'h01);
      @(posedge SYS_CLK) err <= 1'b1;
      repeat (2) wait_rx(5'h14);
      @(posedge SYS_CLK) err <= 1'b0;
      rdv(8'h04);
      chk("sync lost", 0, rd[SQR_MFRAME_SYNC_FLAG_BIT]);
      wait_rx(5'h01);
      chk("fa mirror", 1, TX_FRAME.fa);
      $display("Test sync loss done");
      // Mid-run reset, then network side with multiframing off
      @(posedge SYS_CLK) SYS_RST <= 1'b1;
      @(posedge SYS_CLK) SYS_RST <= 1'b0;
      wr(8'h00, 32'h0000_0009);
      wr(8'h08, 32'h0000_0085);
      for (i = 0; i < 22; i++) begin
         wait_fs(1);
         chk("nt idle", 0, TX_FRAME);
      end
      chk("pin oe", 0, pin_oe);
      // Sync pin held high, then low: hold at 20, restart at frame 1
      wr(8'h00, 32'h0000_0019);
      @(posedge SYS_CLK) pin_in <= 1'b1;
      wait_fs(3);
      chk("nt hold", 0, TX_FRAME);
      @(posedge SYS_CLK) pin_in <= 1'b0;
      for (i = 0; i < 5; i++) begin
         wait_fs((i == 0) ? 1 : 5);
         chk("nt frame", ntx[i], TX_FRAME);
      end
      $display("Test network frames done");
      // Aux pin as general output, then as sync pin per mode
      wr(8'h08, 32'h0000_0080);
      @(posedge SYS_CLK) {gp_out, gp_oe} <= 2'b11;
      repeat (2) @(posedge SYS_CLK);
      #1 chk("gpio", 2'b11, {pin_out, pin_oe});
      wr(8'h08, 32'h0000_0086);
      repeat (2) @(posedge SYS_CLK);
      #1 chk("lts oe", 0, pin_oe);
      wr(8'h08, 32'h0000_0087);
      repeat (2) @(posedge SYS_CLK);
      #1 chk("ltt oe", 1, pin_oe);
      // Data gating cases for TE, NT and LTS modes and every request
      for (i = 0; i < 12; i++) gate(gt[i]);
      $display("Test gating done");
      test_done();
   end
endmodule : stmf_core_tb
`default_nettype wire
